// >>> pio_register_page.sv
// register page, identity code and search response of the eight-channel switch
//
// What this block does
// - holds family, serial and check bytes as identity
// - check uses x8+x5+x4+1 xor feedback shifter
// - check generator starts zero, lsb first
// - all page registers are volatile
// - access only through read and search-write commands
// - two addresses after control read all ones
// - pin-state bit n shows channel pin n
// - pins sampled at msb of preceding byte
// - register reads never pulse the strobe pin
// - output latch shows last channel-access write
// - output latch survives discharge reinitialisation
// - output latch loads all ones (channels off) at power-on
// - activity register shows eight activity latches
// - activity clears on reset, pin reset, command
// - polarity sets required level of chosen source
// - mask and polarity clear on power-on
// - mask and polarity written only by search-write
// - low reset pin sets all output latch bits
// - bytes move least significant bit first
// - response is and or or per combine bit
// - pin function defaults to reset input
`timescale 1ns/1ps
`default_nettype none
module pio_register_page (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // channel pins, reset/strobe pin and supply_present input
    input wire logic [7:0] channel_pin,
    input wire logic reset_or_pulse_pin,
    input wire logic supply_present,
    // command side: byte level access from the protocol engine
    input wire logic [15:0] target_addr,
    input wire logic read_strobe,
    input wire logic sample_strobe,
    input wire logic search_write_strobe,
    input wire logic [7:0] write_data,
    input wire logic channel_write_strobe,
    input wire logic [7:0] channel_write_data,
    input wire logic channel_read_strobe,
    input wire logic clear_activity_strobe,
    input wire logic id_reload,
    input wire logic [5:0] id_bit_index,
    // answers
    output logic [7:0] read_data,
    output logic id_bit,
    output logic [7:0] id_check,
    output logic id_ready,
    output logic search_response_signal,
    output logic access_pulse_output,
    output logic [7:0] channel_drive_n
);
    typedef struct packed {
        logic [2:0] pin_sync0;
        logic [2:0] pin_sync1;
        logic [7:0] pin_a;
        logic [7:0] pin_b;
        logic [7:0] pin_c;
        logic [7:0] pin_stable;
        logic rst_stable;
        logic [7:0] pin_level_snapshot;
        logic [7:0] output_latch_state;
        logic [7:0] activity_latch_state;
        logic [7:0] search_channel_mask;
        logic [7:0] search_channel_polarity;
        logic [3:0] control_bits;
        logic supply_present_flag;
        logic [7:0] read_data;
        logic id_bit;
        logic id_started;
        logic id_busy_d;
        logic [7:0] id_check;
        logic id_ready;
        logic search_response_signal;
        logic access_pulse_output;
    } state_s;

    state_s st;
    state_s next_st;
    pio_page_if link ();
    logic [63:0] id_code;
    logic [7:0] source;
    logic [7:0] match;
    logic pin_reset_active;

    // check generator for the identity code
    id_check_gen u_check (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .link(link)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // identity: family in bits 7:0, serial next, check on top
    assign id_code = {st.id_check, pio_page_pkg::serial_number,
                      pio_page_pkg::family_code};
    assign link.start = !st.id_started || id_reload;
    assign pin_reset_active = !st.rst_stable
        && !st.control_bits[pio_page_pkg::pin_function_bit];

    // search source, polarity match and combine
    always_comb begin
        source = st.control_bits[pio_page_pkg::src_select_bit]
            ? st.activity_latch_state : st.pin_stable;
        match = ~(source ^ st.search_channel_polarity);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // three stage synchronisers; a change counts once stages two and three agree
        next_st.pin_a = channel_pin;
        next_st.pin_b = st.pin_a;
        next_st.pin_c = st.pin_b;
        if (st.pin_b == st.pin_c) begin
            next_st.pin_stable = st.pin_c;
        end
        next_st.pin_sync0 = {st.pin_sync0[1:0], reset_or_pulse_pin};
        next_st.pin_sync1 = {st.pin_sync1[1:0], supply_present};
        if (st.pin_sync0[1] == st.pin_sync0[2]) begin
            next_st.rst_stable = st.pin_sync0[2];
        end
        if (st.pin_sync1[1] == st.pin_sync1[2]) begin
            next_st.supply_present_flag = st.pin_sync1[2];
        end

        // activity latches catch any sampled change on a channel
        next_st.activity_latch_state = st.activity_latch_state
            | (st.pin_stable ^ next_st.pin_stable);

        // capture at msb of byte preceding the pin-state byte
        if (sample_strobe) begin
            next_st.pin_level_snapshot = st.pin_stable;
        end

        // last channel-access write sets the output latch
        if (channel_write_strobe) begin
            next_st.output_latch_state = channel_write_data;
        end
        // low reset pin forces all channels off; pin reset wins over a write
        if (pin_reset_active) begin
            next_st.output_latch_state = pio_page_pkg::latch_off;
        end

        // command or pin reset clears activity; clear takes precedence here
        if (clear_activity_strobe || pin_reset_active) begin
            next_st.activity_latch_state = pio_page_pkg::activity_reset;
        end

        // search-write command is the only write path; read-only addresses drop it
        if (search_write_strobe) begin
            case (target_addr)
                pio_page_pkg::addr_search_mask:
                    next_st.search_channel_mask = write_data;
                pio_page_pkg::addr_search_pol:
                    next_st.search_channel_polarity = write_data;
                pio_page_pkg::addr_control:
                    next_st.control_bits = write_data[3:0]
                        & pio_page_pkg::control_writable[3:0]
                        & {~write_data[pio_page_pkg::power_up_bit]
                           ? 1'b0 : st.control_bits[pio_page_pkg::power_up_bit],
                           3'b111}; // power-up flag can only be cleared
                default: ;
            endcase
        end

        // read answer; page bytes go out lsb first through the engine
        if (read_strobe) begin
            if (target_addr == pio_page_pkg::addr_pin_level) begin
                next_st.read_data = st.pin_level_snapshot;
            end else if (target_addr == pio_page_pkg::addr_out_latch) begin
                next_st.read_data = st.output_latch_state;
            end else if (target_addr == pio_page_pkg::addr_activity) begin
                next_st.read_data = st.activity_latch_state;
            end else if (target_addr == pio_page_pkg::addr_search_mask) begin
                next_st.read_data = st.search_channel_mask;
            end else if (target_addr == pio_page_pkg::addr_search_pol) begin
                next_st.read_data = st.search_channel_polarity;
            end else if (target_addr == pio_page_pkg::addr_control) begin
                next_st.read_data = {st.supply_present_flag, 3'b000, st.control_bits};
            end else if (in_range(target_addr, pio_page_pkg::addr_control + 16'd1,
                                  pio_page_pkg::addr_page_last)) begin
                next_st.read_data = pio_page_pkg::page_filler;
            end else begin
                next_st.read_data = pio_page_pkg::undefined_fill;
            end
        end

        // strobe only for channel reads/writes in strobe mode, never page reads
        next_st.access_pulse_output = !(st.control_bits[pio_page_pkg::pin_function_bit]
            && (channel_write_strobe || channel_read_strobe));

        // conditional search response; power-up flag forces a response
        if (st.search_channel_mask == 8'h00) begin
            next_st.search_response_signal = 1'b0;
        end else if (st.control_bits[pio_page_pkg::combine_bit]) begin
            next_st.search_response_signal = &(match | ~st.search_channel_mask);
        end else begin
            next_st.search_response_signal = |(match & st.search_channel_mask);
        end
        if (st.control_bits[pio_page_pkg::power_up_bit]) begin
            next_st.search_response_signal = 1'b1;
        end

        // identity bit select and check capture
        next_st.id_started = 1'b1;
        next_st.id_busy_d = link.busy;
        next_st.id_bit = id_code[id_bit_index];
        if (st.id_busy_d && !link.busy) begin
            next_st.id_check = link.check;
            next_st.id_ready = 1'b1;
        end else if (link.start) begin
            next_st.id_ready = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers; reset models power-on, no retention
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.search_channel_mask <= pio_page_pkg::mask_reset;
            st.search_channel_polarity <= pio_page_pkg::pol_reset;
            st.activity_latch_state <= pio_page_pkg::activity_reset;
            st.control_bits <= 4'h8; // power-up flag set, pin acts as reset
            st.rst_stable <= 1'b1;
            st.pin_sync0 <= 3'h7; // pin idles high; zeros here fake a pin reset after reset
            st.access_pulse_output <= 1'b1;
            st.output_latch_state <= pio_page_pkg::latch_off;
        end else begin
            st <= next_st; // discharge reinit is not reset_n, latch kept
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign read_data = st.read_data;
    assign id_bit = st.id_bit;
    assign id_check = st.id_check;
    assign id_ready = st.id_ready;
    assign search_response_signal = st.search_response_signal;
    assign access_pulse_output = st.access_pulse_output;
    assign channel_drive_n = st.output_latch_state;
endmodule
`default_nettype wire

// >>> pio_page_pkg.sv
// constants for the register page and identity code of the switch block
package pio_page_pkg;
    localparam logic [15:0] addr_pin_level = 16'h0088;
    localparam logic [15:0] addr_out_latch = 16'h0089;
    localparam logic [15:0] addr_activity = 16'h008A;
    localparam logic [15:0] addr_search_mask = 16'h008B;
    localparam logic [15:0] addr_search_pol = 16'h008C;
    localparam logic [15:0] addr_control = 16'h008D;
    localparam logic [15:0] addr_page_last = 16'h008F;
    localparam logic [7:0] page_filler = 8'hFF;
    localparam logic [7:0] undefined_fill = 8'h00;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic [7:0] pol_reset = 8'h00;
    localparam logic [7:0] activity_reset = 8'h00;
    localparam logic [7:0] latch_off = 8'hFF;
    localparam logic [7:0] control_writable = 8'h0F;
    localparam logic [7:0] crc_seed = 8'h00;
    localparam logic [7:0] crc_poly_rev = 8'h8C;
    localparam int src_select_bit = 0;
    localparam int combine_bit = 1;
    localparam int pin_function_bit = 2;
    localparam int power_up_bit = 3;
    localparam int supply_bit = 7;
    localparam logic [5:0] id_bit_count = 6'd56;
    localparam logic [2:0] byte_last_bit = 3'd7;
    localparam logic [7:0] family_code = 8'h5A; // arbitrary value
    localparam logic [47:0] serial_number = 48'h0000_1234_5678; // arbitrary value
endpackage

// >>> pio_page_if.sv
// bundle between the page core and the identity check generator
`timescale 1ns/1ps
`default_nettype none
interface pio_page_if;
    logic start;
    logic busy;
    logic [7:0] check;
    modport core (output start, input busy, input check);
    modport gen (input start, output busy, output check);
endinterface
`default_nettype wire

// >>> id_check_gen.sv
// serial check generator for the 56 leading identity bits
`timescale 1ns/1ps
`default_nettype none
module id_check_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // link to the core
    pio_page_if.gen link
);
    typedef struct packed {
        logic busy;
        logic [5:0] count;
        logic [7:0] crc;
        logic [7:0] check;
    } state_s;

    state_s st;
    state_s next_st;
    logic [55:0] id_bits;
    logic bit_in;
    logic fb;

    // family code sits in the low byte so it shifts out first
    assign id_bits = {pio_page_pkg::serial_number, pio_page_pkg::family_code};
    assign bit_in = id_bits[st.count];
    assign fb = bit_in ^ st.crc[0];

    // one bit per cycle, lsb first, seed cleared
    always_comb begin
        next_st = st;
        if (link.start && !st.busy) begin
            next_st.busy = 1'b1;
            next_st.count = 6'd0;
            next_st.crc = pio_page_pkg::crc_seed;
        end else if (st.busy) begin
            // reflected x^8+x^5+x^4+1 shift with xor feedback
            next_st.crc = (st.crc >> 1) ^ (fb ? pio_page_pkg::crc_poly_rev : 8'h00);
            next_st.count = st.count + 6'd1;
            if (st.count == pio_page_pkg::id_bit_count - 6'd1) begin
                next_st.busy = 1'b0;
                next_st.check = (st.crc >> 1) ^ (fb ? pio_page_pkg::crc_poly_rev : 8'h00);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.busy = st.busy;
    assign link.check = st.check;
endmodule
`default_nettype wire

// >>> pio_page_monitor.sv
// concurrent checks on the ports of the register page
`timescale 1ns/1ps
`default_nettype none
module pio_page_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // requests
    input wire logic reset_or_pulse_pin,
    input wire logic [15:0] target_addr,
    input wire logic read_strobe,
    input wire logic search_write_strobe,
    input wire logic [7:0] write_data,
    input wire logic channel_write_strobe,
    input wire logic [7:0] channel_write_data,
    input wire logic channel_read_strobe,
    input wire logic id_reload,
    input wire logic [5:0] id_bit_index,
    // answers
    input wire logic [7:0] read_data,
    input wire logic id_bit,
    input wire logic id_ready,
    input wire logic access_pulse_output,
    input wire logic [7:0] channel_drive_n
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_FILLER_BYTES: assert property (
        read_strobe && target_addr[15:1] == 15'h0047 |=> read_data == 8'hFF) else $error("filler");
    AST_NO_READ_PULSE: assert property (
        !access_pulse_output |-> $past(channel_write_strobe || channel_read_strobe))
        else $error("strobe pulse without channel command");
    // the pin passes a synchroniser, so its level three and four edges back decides
    AST_LATCH_LOAD: assert property (
        channel_write_strobe && $past(reset_or_pulse_pin, 3) && $past(reset_or_pulse_pin, 4)
        |=> channel_drive_n == $past(channel_write_data))
        else $error("output latch not loaded");
    AST_LATCH_READ: assert property (
        read_strobe && target_addr == 16'h0089 |=> read_data == $past(channel_drive_n))
        else $error("latch readback wrong");
    AST_MASK_READBACK: assert property (
        search_write_strobe && target_addr == 16'h008B ##2 read_strobe && target_addr == 16'h008B
        |=> read_data == $past(write_data, 3)) else $error("mask readback wrong");
    AST_RO_WRITE: assert property (
        search_write_strobe && target_addr == 16'h0089 && !channel_write_strobe
        && $past(reset_or_pulse_pin, 3) && $past(reset_or_pulse_pin, 4)
        |=> $stable(channel_drive_n)) else $error("read-only write took");
    AST_ID_FAMILY: assert property (
        id_ready && !id_reload && id_bit_index < 6'd8
        |=> id_bit == pio_page_pkg::family_code[$past(id_bit_index[2:0])]) else $error("id bit");
    AST_ID_READY: assert property (
        $rose(reset_n) |-> ##[1:200] id_ready) else $error("check value late");
    AST_RESET_STATE: assert property (disable iff (1'b0)
        !reset_n |=> read_data == 8'h00 && access_pulse_output) else $error("reset state");
    // main scenarios reached
    COV_FILLER: cover property (read_strobe && target_addr == 16'h008F);
    COV_PULSE: cover property (!access_pulse_output);
    COV_MASK: cover property (search_write_strobe && target_addr == 16'h008B);
endmodule
bind pio_register_page pio_page_monitor pio_page_monitor_i (.core_clk, .reset_n,
    .reset_or_pulse_pin, .target_addr, .read_strobe, .search_write_strobe, .write_data,
    .channel_write_strobe, .channel_write_data, .channel_read_strobe, .id_reload,
    .id_bit_index, .read_data, .id_bit, .id_ready, .access_pulse_output, .channel_drive_n);
`default_nettype wire

// >>> bus_master_model.sv
// far-side master model issuing page reads and search-register writes
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // clock
    input wire logic core_clk,
    // page access
    output logic [15:0] target_addr,
    output logic read_strobe,
    output logic search_write_strobe,
    output logic [7:0] write_data,
    input wire logic [7:0] read_data
);
    // idle bus at time zero
    initial begin
        target_addr = 16'h0000;
        read_strobe = 1'b0;
        search_write_strobe = 1'b0;
        write_data = 8'h00;
    end
    // read one byte; released lines show the inverse so stale values never pass
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge core_clk);
        target_addr = a;
        read_strobe = 1'b1;
        @(negedge core_clk);
        d = read_data;
        read_strobe = 1'b0;
        target_addr = ~a;
    endtask
    // write one byte through the search-register write path
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        target_addr = a;
        write_data = d;
        search_write_strobe = 1'b1;
        @(negedge core_clk);
        search_write_strobe = 1'b0;
        target_addr = ~a;
        write_data = ~d;
    endtask
endmodule
`default_nettype wire

// >>> test_pio_register_page.sv
// self-checking bench for the register page and identity code
`timescale 1ns/1ps
`default_nettype none
module test_pio_register_page;
    logic core_clk, id_bit, id_ready, search_response_signal, access_pulse_output, pulse_seen;
    logic reset_n = 1'b0, reset_or_pulse_pin = 1'b1, supply_present = 1'b1, id_reload = 1'b0;
    logic sample_strobe = 1'b0, clear_activity_strobe = 1'b0, channel_read_strobe = 1'b0;
    logic channel_write_strobe = 1'b0, read_strobe, search_write_strobe;
    logic [7:0] channel_pin = 8'h00, channel_write_data = 8'h00, write_data, read_data;
    logic [7:0] id_check, channel_drive_n, snap, latch = 8'hFF, act = 8'h00, mask = 8'h00;
    logic [7:0] pins = 8'h00, pol = 8'h00, ctrl = 8'h08;
    logic [5:0] id_bit_index = 6'h00;
    logic [15:0] target_addr;
    logic [63:0] id;
    int n_fail = 0, check_count = 0, k;
    pio_register_page pio_register_page_i (.core_clk, .reset_n, .channel_pin,
        .reset_or_pulse_pin, .supply_present, .target_addr, .read_strobe, .sample_strobe,
        .search_write_strobe, .write_data, .channel_write_strobe, .channel_write_data,
        .channel_read_strobe, .clear_activity_strobe, .id_reload, .id_bit_index, .read_data,
        .id_bit, .id_check, .id_ready, .search_response_signal, .access_pulse_output,
        .channel_drive_n);
    bus_master_model bus_master_model_i (.core_clk, .target_addr, .read_strobe,
        .search_write_strobe, .write_data, .read_data);
    // ------------------------------------------------------------
    // clock, checks and reference model
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic report_and_stop;
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // expected page contents from the model state
    function automatic logic [7:0] ev(input logic [15:0] a);
        case (a)
            16'h0088: return snap;
            16'h0089: return latch;
            16'h008A: return act;
            16'h008B: return mask;
            16'h008C: return pol;
            16'h008D: return {supply_present, 3'b000, ctrl[3:0]};
            16'h008E, 16'h008F: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
        return c;
    endfunction
    // pin or latch source, and or or per combine bit; power-up flag forces a response
    function automatic logic resp;
        logic [7:0] m;
        m = ~((ctrl[0] ? act : pins) ^ pol) & mask;
        return ctrl[3] || (ctrl[1] ? (mask != 8'h00 && m == mask) : (m != 8'h00));
    endfunction
    task automatic rchk(input logic [15:0] a);
        logic [7:0] d;
        bus_master_model_i.rd(a, d);
        chk(d, ev(a));
        chk({7'h00, access_pulse_output}, 8'h01);
    endtask
    task automatic sweep;
        for (int a = 16'h0086; a <= 16'h008F; a++) rchk(16'(a));
        chk(channel_drive_n, latch);
    endtask
    // bounded wait for the identity check value; running out counts as a failure
    task automatic wait_id;
        for (k = 0; k < 300 && id_ready !== 1'b1; k++) @(negedge core_clk);
        if (k == 300) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_master_model_i.wr(a, d);
        if (a == 16'h008B) mask = d;
        if (a == 16'h008C) pol = d;
        if (a == 16'h008D) ctrl = (ctrl & d & 8'h08) | (d & 8'h07);
    endtask
    // one-cycle command strobe; s picks channel read, clear activity, sample or channel write
    task automatic strobe(input int s, input logic [7:0] d);
        @(negedge core_clk);
        {channel_write_strobe, sample_strobe, clear_activity_strobe, channel_read_strobe} = 4'(1 << s);
        channel_write_data = d;
        @(negedge core_clk);
        pulse_seen = access_pulse_output;
        {channel_write_strobe, sample_strobe, clear_activity_strobe, channel_read_strobe} = 4'h0;
        if (s == 3) latch = d;
        if (s == 2) snap = pins;
        if (s == 1) act = 8'h00;
    endtask
    task automatic setpins(input logic [7:0] v);
        @(negedge core_clk);
        channel_pin = v;
        act = act | (pins ^ v);
        pins = v;
        repeat (8) @(negedge core_clk);
    endtask
    // low pulse on the reset pin; only a reset input sets the latch to all ones and clears activity
    task automatic pin_pulse;
        @(negedge core_clk);
        reset_or_pulse_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        reset_or_pulse_pin = 1'b1;
        repeat (10) @(negedge core_clk);
        if (!ctrl[2]) {latch, act} = 16'hFF00;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hA6B3));
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        chk({7'h00, search_response_signal}, 8'h01);
        strobe(2, 8'h00);
        sweep();
        wait_id();
        id = {8'h00, pio_page_pkg::serial_number, pio_page_pkg::family_code};
        id[63:56] = crc8(id, 56);
        chk(id_check, id[63:56]);
        chk(crc8({id_check, id[55:0]}, 64), 8'h00);
        for (k = 0; k < 64; k++) begin
            id_bit_index = 6'(k);
            @(negedge core_clk);
            chk({7'h00, id_bit}, {7'h00, id[k]});
        end
        // recompute on request: ready drops, then the same check value returns
        id_reload = 1'b1;
        @(negedge core_clk);
        id_reload = 1'b0;
        chk({7'h00, id_ready}, 8'h00);
        wait_id();
        chk(id_check, id[63:56]);
        repeat (6) begin
            wr(16'h008B, 8'($urandom));
            rchk(16'h008B);
            wr(16'h008C, 8'($urandom));
            wr(16'h008D, 8'($urandom) & 8'hFB);
            wr(16'h0088 + 16'($urandom_range(0, 2)), 8'($urandom));
            wr(16'h008E, 8'($urandom));
        end
        repeat (4) begin
            strobe(3, 8'($urandom));
            chk({7'h00, pulse_seen}, 8'h01);
            supply_present = 1'($urandom);
            setpins(8'($urandom));
            strobe(2, 8'h00);
            sweep();
        end
        strobe(1, 8'h00);
        setpins(~pins);
        pin_pulse();
        sweep();
        wr(16'h008D, 8'h04);
        strobe(3, 8'($urandom));
        chk({7'h00, pulse_seen}, 8'h00);
        strobe(0, 8'h00);
        chk({7'h00, pulse_seen}, 8'h00);
        pin_pulse();
        sweep();
        wr(16'h008D, 8'h00);
        for (k = 0; k < 16; k++) begin
            wr(16'h008D, 8'(k % 4));
            wr(16'h008B, (k < 4) ? 8'h00 : ((k < 8) ? 8'hFF : 8'($urandom)));
            wr(16'h008C, 8'($urandom));
            setpins(8'($urandom));
            chk({7'h00, search_response_signal}, {7'h00, resp()});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
